// file: hw/rct_pkg.sv
/*
  rct_pkg: shared constants and types for the relay closure tally block.
  Assumes a 250 MHz single clock; every slower rate is an enable pulse.
*/
package rct_pkg;

  // clock and minute timebase
  localparam longint unsigned CLK_HZ      = 64'd250_000_000;
  localparam longint unsigned SEC_PER_MIN = 64'd60;
  localparam longint unsigned CYC_PER_MIN = CLK_HZ * SEC_PER_MIN;

  // flush period in whole minutes
  localparam int unsigned PERIOD_W       = 11;
  localparam logic [10:0] PERIOD_MIN     = 11'h00a;  // 10 minutes
  localparam logic [10:0] PERIOD_MAX     = 11'h5a0;  // 1440 minutes
  localparam logic [10:0] PERIOD_DEFAULT = 11'h00f;  // 15 minutes

  // widths of tallies, command data and channel identifiers
  localparam int unsigned TALLY_W    = 32;
  localparam int unsigned VAL_W      = 32;
  localparam int unsigned ID_W       = 10;
  localparam int unsigned SLOT_RADIX = 100;  // slot in hundreds digit

  // commands from the remote command decoder
  typedef enum logic [2:0] {
    RCT_OP_TALLY_QUERY,
    RCT_OP_PERIOD_SET,
    RCT_OP_PERIOD_QUERY,
    RCT_OP_TALLY_CLEAR,
    RCT_OP_CAL_UNLOCK,
    RCT_OP_CAL_RELOCK
  } rct_op_type;

endpackage : rct_pkg

// file: hw/rct_flush_if.sv
/*
  rct_flush_if: carries the flush period and the flush-due handshake
  between the tally core and its minute timer. Same clock on both ends.
*/
`timescale 1ns/1ps
`default_nettype none

interface rct_flush_if;
  import rct_pkg::*;
  logic [PERIOD_W-1:0] period;   // programmed period, minutes
  logic                restart;  // pulse: restart the period count
  logic                due;      // level: period has expired

  modport core  (output period, output restart, input due);
  modport timer (input period, input restart, output due);
endinterface : rct_flush_if

`default_nettype wire

// file: hw/rct_flush_timer.sv
/*
  rct_flush_timer: minute divider and flush period counter.
  Assumes the core holds the period stable and pulses restart after
  every flush and every period change.
*/
`timescale 1ns/1ps
`default_nettype none

module rct_flush_timer
  import rct_pkg::*;
#(
  parameter longint unsigned CYC_MIN = CYC_PER_MIN
) (
  input  wire logic    mclk_i,
  input  wire logic    rst_n_i,
  rct_flush_if.timer   tif
);

  localparam int unsigned CNT_W = $clog2(CYC_MIN + 1);

  if (CYC_MIN < 2) begin : g_chk
    $error("rct_flush_timer: CYC_MIN must be at least 2");
  end

  logic [CNT_W-1:0]    cyc_q;
  logic [PERIOD_W-1:0] min_q;
  logic                min_tick;
  logic                hit;
  logic                due_q;

  // one-cycle minute enable
  assign min_tick = (cyc_q == CNT_W'(CYC_MIN - 1));
  assign hit      = min_tick && ((min_q + 1'b1) >= tif.period);
  assign tif.due  = due_q;

  // cycle divider, realigned on restart so a period is never short
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cyc_q <= '0;
    end else if (tif.restart || min_tick) begin
      cyc_q <= '0;
    end else begin
      cyc_q <= cyc_q + 1'b1;
    end
  end

  // minutes elapsed since the last restart or expiry
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      min_q <= '0;
    end else if (tif.restart || hit) begin
      min_q <= '0;
    end else if (min_tick) begin
      min_q <= min_q + 1'b1;
    end
  end

  // due stays up until the core restarts; expiry wins over restart
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      due_q <= 1'b0;
    end else begin
      due_q <= hit || (due_q && !tif.restart);  // R4
    end
  end

endmodule : rct_flush_timer

`default_nettype wire

// file: hw/rct_tally.sv
/*
  rct_tally: per-channel relay closure tallies, flush to card EEPROM,
  remote command handling. Assumes relay states and commands come from
  logic on mclk_i; only the calibration strap is a raw pin.
*/
// Functional notes
// R1: count only open-to-closed relay transitions
// R2: repeated closes without open count once
// R3: every closure updates volatile tally, any source
// R4: EEPROM write only on period expiry or query
// R5: flush period is fifteen minutes after reset
// R6: period whole minutes, 10 to 1440
// R7: period query returns programmed period
// R8: tally query returns each listed channel's tally
// R9: identifier is slot hundreds, channel two digits; ranges
// R10: clear zeroes listed tallies only in calibration
// R11: host unlocks before clear, relocks after
// R12: tally read or clear only from remote
// R13: reject bad period or locked clear, unchanged
`timescale 1ns/1ps
`default_nettype none

module rct_tally
  import rct_pkg::*;
#(
  parameter int unsigned     SLOTS       = 2,
  parameter int unsigned     CPS         = 40,
  parameter longint unsigned CYC_MIN     = CYC_PER_MIN,
  parameter logic [31:0]     UNLOCK_CODE = 32'h5a5a_c3c3  // arbitrary value
) (
  input  wire logic                  mclk_i,
  input  wire logic                  rst_n_i,
  input  wire logic [SLOTS*CPS-1:0]  relay_closed_i,
  input  wire logic                  cal_boot_i,
  input  wire logic                  cmd_valid_i,
  output logic                       cmd_ready_o,
  input  wire logic [2:0]            cmd_op_i,
  input  wire logic                  cmd_remote_i,
  input  wire logic [ID_W-1:0]       cmd_first_i,
  input  wire logic [ID_W-1:0]       cmd_last_i,
  input  wire logic [VAL_W-1:0]      cmd_value_i,
  output logic                       rsp_valid_o,
  output logic [TALLY_W-1:0]         rsp_data_o,
  output logic                       rsp_last_o,
  output logic                       rsp_err_o,
  output logic                       cal_open_o,
  output logic                       ee_wr_valid_o,
  input  wire logic                  ee_wr_ready_i,
  output logic [$clog2(SLOTS*CPS)-1:0] ee_wr_addr_o,
  output logic [TALLY_W-1:0]         ee_wr_data_o
);

  localparam int unsigned NCH   = SLOTS * CPS;
  localparam int unsigned IDX_W = $clog2(NCH);

  if (SLOTS < 1 || SLOTS > 9 || CPS < 2 || CPS > 99) begin : g_chk
    $error("rct_tally: SLOTS must be 1..9 and CPS 2..99");
  end

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_QUERY,
    ST_CLEAR,
    ST_FLUSH
  } rct_state_type;

  // decode slot*100+channel into {bad, flat index}
  function automatic logic [IDX_W:0] chan_decode(input logic [ID_W-1:0] id);
    int unsigned slot;
    int unsigned ch;
    slot = int'(id) / SLOT_RADIX;
    ch   = int'(id) % SLOT_RADIX;
    if (slot < 1 || slot > SLOTS || ch < 1 || ch > CPS) begin
      chan_decode = {1'b1, {IDX_W{1'b0}}};
    end else begin
      chan_decode = {1'b0, IDX_W'((slot - 1) * CPS + ch - 1)};
    end
  endfunction : chan_decode

  rct_flush_if fif ();

  rct_flush_timer #(
    .CYC_MIN (CYC_MIN)
  ) u_timer (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .tif     (fif)
  );

  rct_state_type       state_q;
  logic [TALLY_W-1:0]  tally_q [NCH];
  logic [NCH-1:0]      prev_q;
  logic [NCH-1:0]      rise;
  logic [IDX_W-1:0]    idx_q;
  logic [IDX_W-1:0]    last_q;
  logic [PERIOD_W-1:0] period_q;
  logic                strap_m_q;
  logic                strap_s_q;
  logic [2:0]          strap_taken_q;
  logic                cal_armed_q;
  logic                cal_open_q;
  logic                restart_q;
  logic                rsp_valid_q;
  logic [TALLY_W-1:0]  rsp_data_q;
  logic                rsp_last_q;
  logic                rsp_err_q;
  logic                ee_valid_q;
  logic [IDX_W-1:0]    ee_addr_q;
  logic [TALLY_W-1:0]  ee_data_q;
  logic                take;
  rct_op_type          op;
  logic [IDX_W:0]      dec_first;
  logic [IDX_W:0]      dec_last;
  logic                list_ok;
  logic                period_ok;
  logic                list_op;
  logic                refuse;
  logic                clr_now;
  logic                ee_done;

  assign op          = rct_op_type'(cmd_op_i);
  assign cmd_ready_o = (state_q == ST_IDLE);
  assign take        = cmd_valid_i && cmd_ready_o;
  assign dec_first   = chan_decode(cmd_first_i);  // R9
  assign dec_last    = chan_decode(cmd_last_i);   // R9
  assign list_ok     = !dec_first[IDX_W] && !dec_last[IDX_W]
                       && (dec_first[IDX_W-1:0] <= dec_last[IDX_W-1:0]);
  assign period_ok   = (cmd_value_i >= VAL_W'(PERIOD_MIN))
                       && (cmd_value_i <= VAL_W'(PERIOD_MAX));  // R6
  assign list_op     = (op == RCT_OP_TALLY_QUERY) || (op == RCT_OP_TALLY_CLEAR);

  // refusal: local tally access, bad list, bad period, locked clear, unlock with wrong code or strap not armed
  always_comb begin
    refuse = 1'b0;
    if (list_op && (!cmd_remote_i || !list_ok)) begin
      refuse = 1'b1;  // R12
    end
    if (op == RCT_OP_PERIOD_SET && !period_ok) begin
      refuse = 1'b1;  // R13
    end
    if (op == RCT_OP_TALLY_CLEAR && !cal_open_q) begin
      refuse = 1'b1;  // R13
    end
    if (op == RCT_OP_CAL_UNLOCK && (!cal_armed_q || cmd_value_i != UNLOCK_CODE)) begin
      refuse = 1'b1;
    end
  end

  assign clr_now = (state_q == ST_CLEAR);
  assign ee_done = ee_valid_q && ee_wr_ready_i;

  // closure edge detect; relays settle in this domain already
  assign rise = relay_closed_i & ~prev_q;  // R1

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_q <= '0;
    end else begin
      prev_q <= relay_closed_i;  // R2
    end
  end

  // volatile tallies; a closure in the clear cycle still counts
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < NCH; i++) begin
        tally_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (clr_now && idx_q == IDX_W'(i)) begin
          tally_q[i] <= rise[i] ? TALLY_W'(1) : '0;  // R10
        end else if (rise[i]) begin
          tally_q[i] <= tally_q[i] + 1'b1;  // R3
        end
      end
    end
  end

  // calibration strap: two flops, taken at third edge after release
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_m_q     <= 1'b0;
      strap_s_q     <= 1'b0;
      strap_taken_q <= '0;
      cal_armed_q   <= 1'b0;
    end else begin
      strap_m_q     <= cal_boot_i;
      strap_s_q     <= strap_m_q;
      strap_taken_q <= {strap_taken_q[1:0], 1'b1};
      if (!strap_taken_q[2]) begin
        cal_armed_q <= strap_s_q;
      end
    end
  end

  // calibration unlock and relock, from remote or local commands alike
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cal_open_q <= 1'b0;
    end else if (take && op == RCT_OP_CAL_UNLOCK && !refuse) begin
      cal_open_q <= 1'b1;
    end else if (take && op == RCT_OP_CAL_RELOCK) begin
      cal_open_q <= 1'b0;
    end
  end

  // flush period, default fifteen minutes
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      period_q <= PERIOD_DEFAULT;  // R5
    end else if (take && op == RCT_OP_PERIOD_SET && !refuse) begin
      period_q <= PERIOD_W'(cmd_value_i);  // R6
    end
  end

  // main sequencer: commands win over a pending flush
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
      idx_q   <= '0;
      last_q  <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (take && list_op && !refuse) begin
            idx_q   <= dec_first[IDX_W-1:0];
            last_q  <= dec_last[IDX_W-1:0];
            state_q <= (op == RCT_OP_TALLY_QUERY) ? ST_QUERY : ST_CLEAR;
          end else if (!cmd_valid_i && fif.due) begin
            idx_q   <= '0;
            state_q <= ST_FLUSH;  // R4
          end
        end
        ST_QUERY, ST_CLEAR: begin
          if (idx_q == last_q) begin
            idx_q   <= '0;
            state_q <= (state_q == ST_QUERY) ? ST_FLUSH : ST_IDLE;  // R4
          end else begin
            idx_q <= idx_q + 1'b1;
          end
        end
        ST_FLUSH: begin
          if (ee_done) begin
            if (idx_q == IDX_W'(NCH - 1)) begin
              state_q <= ST_IDLE;
            end else begin
              idx_q <= idx_q + 1'b1;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // restart timer after each full flush or a new period
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      restart_q <= 1'b0;
    end else begin
      restart_q <= (ee_done && idx_q == IDX_W'(NCH - 1))
                   || (take && op == RCT_OP_PERIOD_SET && !refuse);
    end
  end

  assign fif.period  = period_q;
  assign fif.restart = restart_q;

  // EEPROM word: snapshot into flops, hold until accepted
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ee_valid_q <= 1'b0;
      ee_addr_q  <= '0;
      ee_data_q  <= '0;
    end else if (ee_done) begin
      ee_valid_q <= 1'b0;
    end else if (state_q == ST_FLUSH && !ee_valid_q) begin
      ee_valid_q <= 1'b1;  // R4
      ee_addr_q  <= idx_q;
      ee_data_q  <= tally_q[idx_q];
    end
  end

  // answers: one word per queried channel, one per clear or other command
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q  <= '0;
      rsp_last_q  <= 1'b0;
      rsp_err_q   <= 1'b0;
    end else begin
      rsp_valid_q <= 1'b0;
      rsp_last_q  <= 1'b0;
      rsp_err_q   <= 1'b0;
      if (state_q == ST_QUERY) begin
        rsp_valid_q <= 1'b1;
        rsp_data_q  <= tally_q[idx_q];  // R8
        rsp_last_q  <= (idx_q == last_q);
      end else if (state_q == ST_CLEAR && idx_q == last_q) begin
        rsp_valid_q <= 1'b1;
        rsp_data_q  <= '0;
        rsp_last_q  <= 1'b1;
      end else if (take && (refuse || !list_op)) begin
        rsp_valid_q <= 1'b1;
        rsp_last_q  <= 1'b1;
        rsp_err_q   <= refuse;  // R13
        rsp_data_q  <= (op == RCT_OP_PERIOD_QUERY) ? TALLY_W'(period_q) : '0;  // R7
      end
    end
  end

  assign rsp_valid_o   = rsp_valid_q;
  assign rsp_data_o    = rsp_data_q;
  assign rsp_last_o    = rsp_last_q;
  assign rsp_err_o     = rsp_err_q;
  assign cal_open_o    = cal_open_q;
  assign ee_wr_valid_o = ee_valid_q;
  assign ee_wr_addr_o  = ee_addr_q;
  assign ee_wr_data_o  = ee_data_q;

  // checks on channel 0, on the EEPROM flush and on the command path
  property p_step;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (rise[0] && !(clr_now && idx_q == '0)) |=> tally_q[0] == $past(tally_q[0]) + 1'b1;
  endproperty
  a_step: assert property (p_step) else $error("closure not counted");  // R1

  property p_hold;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (relay_closed_i[0] && prev_q[0] && !clr_now) |=> $stable(tally_q[0]);
  endproperty
  a_hold: assert property (p_hold) else $error("held closure counted");  // R2

  property p_ee_flush;
    @(posedge mclk_i) disable iff (!rst_n_i)
    $rose(ee_wr_valid_o) |-> $past(state_q) == ST_FLUSH;
  endproperty
  a_ee_flush: assert property (p_ee_flush) else $error("EEPROM write outside flush");  // R4

  property p_query_flush;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (state_q == ST_QUERY && idx_q == last_q) |=> state_q == ST_FLUSH ##[1:2] ee_wr_valid_o;
  endproperty
  a_query_flush: assert property (p_query_flush) else $error("query did not flush");  // R4

  property p_range;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (period_q >= PERIOD_MIN) && (period_q <= PERIOD_MAX);
  endproperty
  a_range: assert property (p_range) else $error("period out of range");  // R6

  property p_period_reply;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (take && op == RCT_OP_PERIOD_QUERY) |=> rsp_valid_o && rsp_data_o == TALLY_W'($past(period_q));
  endproperty
  a_period_reply: assert property (p_period_reply) else $error("bad period reply");  // R7

  property p_tally_reply;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (state_q == ST_QUERY) |=> rsp_valid_o && rsp_data_o == $past(tally_q[idx_q]);
  endproperty
  a_tally_reply: assert property (p_tally_reply) else $error("bad tally reply");  // R8

  property p_clear_open;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (state_q == ST_CLEAR) |-> cal_open_q;
  endproperty
  a_clear_open: assert property (p_clear_open) else $error("clear while locked");  // R10

  property p_local;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (take && list_op && !cmd_remote_i) |=> rsp_err_o && state_q == ST_IDLE;
  endproperty
  a_local: assert property (p_local) else $error("local tally access taken");  // R12

  property p_bad_period;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (take && op == RCT_OP_PERIOD_SET && !period_ok) |=> rsp_err_o && $stable(period_q);
  endproperty
  a_bad_period: assert property (p_bad_period) else $error("bad period stored");  // R13

  c_query: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    state_q == ST_QUERY ##1 state_q == ST_QUERY);
  c_clear: cover property (@(posedge mclk_i) disable iff (!rst_n_i) state_q == ST_CLEAR);
  c_timed_flush: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    state_q == ST_IDLE && fif.due ##1 state_q == ST_FLUSH);

endmodule : rct_tally

`default_nettype wire

// file: test/rct_host_model.sv
/*
  rct_host_model: remote host sending tally commands.
  Assumes one clock; drives on the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none

module rct_host_model
  import rct_pkg::*;
(
  input  wire logic               mclk_i,
  input  wire logic               cmd_ready_i,
  input  wire logic               rsp_valid_i,
  input  wire logic [TALLY_W-1:0] rsp_data_i,
  input  wire logic               rsp_last_i,
  input  wire logic               rsp_err_i,
  output logic                    cmd_valid_o,
  output logic [2:0]              cmd_op_o,
  output logic                    cmd_remote_o,
  output logic [ID_W-1:0]         cmd_first_o,
  output logic [ID_W-1:0]         cmd_last_o,
  output logic [VAL_W-1:0]        cmd_value_o
);
  logic [TALLY_W-1:0] rsp_q[$];
  logic               err_seen;
  logic               done_seen;

  // idle lines start low
  initial begin
    cmd_valid_o = 1'b0;
    {cmd_op_o, cmd_remote_o, cmd_first_o, cmd_last_o, cmd_value_o} = '0;
    err_seen    = 1'b0;
    done_seen   = 1'b0;
  end

  // slot in hundreds, channel in low digits
  function automatic logic [ID_W-1:0] chan_id(input int slot, input int chan);
    return ID_W'(slot * SLOT_RADIX + chan);
  endfunction : chan_id

  // fields held until taken, then answers gathered up to the last word
  task automatic send(input rct_op_type op, input logic remote, input logic [ID_W-1:0] first,
                      input logic [ID_W-1:0] last, input logic [VAL_W-1:0] value);
    int n;
    rsp_q.delete();
    err_seen  = 1'b0;
    done_seen = 1'b0;
    @(negedge mclk_i);
    {cmd_op_o, cmd_remote_o, cmd_first_o, cmd_last_o, cmd_value_o} = {op, remote, first, last, value};
    cmd_valid_o = 1'b1;
    for (n = 0; n < 2000 && cmd_ready_i !== 1'b1; n++)
      @(negedge mclk_i);
    @(negedge mclk_i);
    // released lines show the inverse so stale values never match
    {cmd_op_o, cmd_remote_o, cmd_first_o, cmd_last_o, cmd_value_o} = ~{op, remote, first, last, value};
    cmd_valid_o = 1'b0;
    for (n = 0; n < 400 && !done_seen; n++) begin
      if (rsp_valid_i === 1'b1) begin
        rsp_q.push_back(rsp_data_i);
        err_seen  = err_seen | (rsp_err_i === 1'b1);
        done_seen = (rsp_last_i === 1'b1);
      end
      if (!done_seen)
        @(negedge mclk_i);
    end
  endtask : send

  // clearing needs calibration opened before and closed after
  task automatic cal_clear(input logic [ID_W-1:0] first, input logic [ID_W-1:0] last,
                           input logic [VAL_W-1:0] code, output logic unl_err,
                           output logic clr_err, output logic [TALLY_W-1:0] clr_word);
    send(RCT_OP_CAL_UNLOCK, 1'b1, '0, '0, code);
    unl_err  = err_seen;
    send(RCT_OP_TALLY_CLEAR, 1'b1, first, last, '0);
    clr_err  = err_seen;
    clr_word = rsp_q.size() > 0 ? rsp_q[0] : '1;
    send(RCT_OP_CAL_RELOCK, 1'b1, '0, '0, '0);
  endtask : cal_clear
endmodule : rct_host_model

`default_nettype wire

// file: test/rct_tally_tb.sv
/*
  rct_tally_tb: self-checking bench for rct_tally with a host model.
  Assumes a shortened minute (4 cycles) and 2 slots of 4 channels.
*/
`timescale 1ns/1ps
`default_nettype none

module rct_tally_tb;
  import rct_pkg::*;
  localparam int          NCH  = 8;
  localparam int          CPS  = 4;
  localparam logic [31:0] CODE = 32'h1234_abcd;  // arbitrary value

  logic              mclk_i;
  logic              rst_n_i;
  logic [NCH-1:0]    relay_closed;
  logic              cmd_valid;
  logic              cmd_ready;
  logic [2:0]        cmd_op;
  logic              cmd_remote;
  logic [ID_W-1:0]   cmd_first;
  logic [ID_W-1:0]   cmd_last;
  logic [VAL_W-1:0]  cmd_value;
  logic              rsp_valid;
  logic [31:0]       rsp_data;
  logic              rsp_last;
  logic              rsp_err;
  logic              cal_open;
  logic              ee_valid;
  logic              ee_ready;
  logic [2:0]        ee_addr;
  logic [31:0]       ee_data;
  logic [31:0]       exp_t[NCH];
  logic [2:0]        ee_addr_q[$];
  logic [31:0]       ee_data_q[$];
  int                stall_cnt;
  int                bad_count;
  int                check_count;

  rct_tally #(.SLOTS(2), .CPS(CPS), .CYC_MIN(4), .UNLOCK_CODE(CODE)) rct_tally_i (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .relay_closed_i(relay_closed), .cal_boot_i(1'b1),
    .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_op_i(cmd_op), .cmd_remote_i(cmd_remote),
    .cmd_first_i(cmd_first), .cmd_last_i(cmd_last), .cmd_value_i(cmd_value),
    .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .rsp_last_o(rsp_last), .rsp_err_o(rsp_err),
    .cal_open_o(cal_open), .ee_wr_valid_o(ee_valid), .ee_wr_ready_i(ee_ready),
    .ee_wr_addr_o(ee_addr), .ee_wr_data_o(ee_data));

  rct_host_model rct_host_model_i (
    .mclk_i(mclk_i), .cmd_ready_i(cmd_ready), .rsp_valid_i(rsp_valid), .rsp_data_i(rsp_data),
    .rsp_last_i(rsp_last), .rsp_err_i(rsp_err), .cmd_valid_o(cmd_valid), .cmd_op_o(cmd_op),
    .cmd_remote_o(cmd_remote), .cmd_first_o(cmd_first), .cmd_last_o(cmd_last),
    .cmd_value_o(cmd_value));

  // clock
  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end

  // eeprom sink stalls one edge in three; words logged where taken
  always @(negedge mclk_i) begin : ee_sink
    logic nxt;
    stall_cnt = stall_cnt + 1;
    nxt = (stall_cnt % 3) != 0;
    ee_ready <= nxt;
    if (ee_valid === 1'b1 && nxt) begin
      ee_addr_q.push_back(ee_addr);
      ee_data_q.push_back(ee_data);
    end
  end

  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word

  task automatic check_bit(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  function automatic logic [ID_W-1:0] fid(input int k);
    return rct_host_model_i.chan_id(k / CPS + 1, k % CPS + 1);
  endfunction : fid

  // relay closed for hold cycles, then open
  task automatic close_relay(input int k, input int hold);
    @(negedge mclk_i);
    relay_closed[k] = 1'b1;
    exp_t[k]++;
    repeat (hold) @(negedge mclk_i);
    relay_closed[k] = 1'b0;
  endtask : close_relay

  task automatic check_query(input int f, input int l);
    int k;
    rct_host_model_i.send(RCT_OP_TALLY_QUERY, 1'b1, fid(f), fid(l), '0);
    check_word("query words", 32'(l - f + 1), 32'(rct_host_model_i.rsp_q.size()));
    check_bit("query err", 1'b0, rct_host_model_i.err_seen);
    for (k = f; k <= l && k - f < rct_host_model_i.rsp_q.size(); k++)
      check_word("tally", exp_t[k], rct_host_model_i.rsp_q[k - f]);
  endtask : check_query

  task automatic check_flush();
    int n;
    for (n = 0; n < 300 && ee_addr_q.size() < NCH; n++)
      @(negedge mclk_i);
    check_word("flush words", 32'(NCH), 32'(ee_addr_q.size()));
    for (n = 0; n < NCH && n < ee_addr_q.size(); n++) begin
      check_word("ee addr", 32'(n), 32'(ee_addr_q[n]));
      check_word("ee data", exp_t[n], ee_data_q[n]);
    end
  endtask : check_flush

  task automatic t_reset();
    check_bit("ready", 1'b1, cmd_ready);
    check_bit("rsp valid", 1'b0, rsp_valid);
    check_bit("ee valid", 1'b0, ee_valid);
    check_bit("cal open", 1'b0, cal_open);
    rct_host_model_i.send(RCT_OP_PERIOD_QUERY, 1'b0, '0, '0, '0);
    check_word("period", 32'h0000_000f, rct_host_model_i.rsp_q[0]);
  endtask : t_reset

  // closures, held closes, simultaneous closes, then query and its flush
  task automatic t_count();
    close_relay(0, 1);
    close_relay(0, 6);
    close_relay(5, 2);
    @(negedge mclk_i);
    relay_closed[3:1] = 3'h7;
    exp_t[1]++;
    exp_t[2]++;
    exp_t[3]++;
    repeat (3) @(negedge mclk_i);
    relay_closed[2:1] = 2'h0;
    check_query(0, NCH - 1);
    ee_addr_q.delete();
    ee_data_q.delete();
    check_flush();
    check_query(2, 5);
  endtask : t_count

  // no write before the period runs out, then a full timed flush
  task automatic t_timer();
    rct_host_model_i.send(RCT_OP_PERIOD_SET, 1'b1, '0, '0, 32'h0000_000a);
    ee_addr_q.delete();
    ee_data_q.delete();
    close_relay(7, 1);
    repeat (26) @(negedge mclk_i);
    check_word("early writes", 32'h0, 32'(ee_addr_q.size()));
    check_flush();
  endtask : t_timer

  task automatic t_period();
    logic [31:0] vals[5] = '{32'h009, 32'h5a1, 32'h00a, 32'h000, 32'h5a0};
    logic        bad[5]  = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    logic [31:0] per[5]  = '{32'h00a, 32'h00a, 32'h00a, 32'h00a, 32'h5a0};
    int          i;
    for (i = 0; i < 5; i++) begin
      rct_host_model_i.send(RCT_OP_PERIOD_SET, 1'b1, '0, '0, vals[i]);
      check_bit("set refused", bad[i], rct_host_model_i.err_seen);
      rct_host_model_i.send(RCT_OP_PERIOD_QUERY, 1'b1, '0, '0, '0);
      check_word("period", per[i], rct_host_model_i.rsp_q[0]);
    end
  endtask : t_period

  task automatic t_refuse();
    int fs[4] = '{3, 1, 1, 1};
    int fc[4] = '{1, 0, 5, 2};
    int lc[4] = '{1, 0, 5, 1};
    int i;
    rct_host_model_i.send(RCT_OP_TALLY_QUERY, 1'b0, fid(0), fid(1), '0);
    check_bit("local query", 1'b1, rct_host_model_i.err_seen);
    for (i = 0; i < 4; i++) begin
      rct_host_model_i.send(RCT_OP_TALLY_QUERY, 1'b1, rct_host_model_i.chan_id(fs[i], fc[i]),
                            rct_host_model_i.chan_id(fs[i], lc[i]), '0);
      check_bit("bad list", 1'b1, rct_host_model_i.err_seen);
    end
  endtask : t_refuse

  task automatic t_clear();
    logic        ue;
    logic        ce;
    logic [31:0] cw;
    rct_host_model_i.send(RCT_OP_TALLY_CLEAR, 1'b1, fid(0), fid(1), '0);
    check_bit("locked clear", 1'b1, rct_host_model_i.err_seen);
    rct_host_model_i.send(RCT_OP_CAL_UNLOCK, 1'b1, '0, '0, ~CODE);
    check_bit("wrong code", 1'b1, rct_host_model_i.err_seen);
    check_bit("cal open", 1'b0, cal_open);
    rct_host_model_i.send(RCT_OP_CAL_UNLOCK, 1'b1, '0, '0, CODE);
    check_bit("cal open", 1'b1, cal_open);
    rct_host_model_i.send(RCT_OP_TALLY_CLEAR, 1'b0, fid(0), fid(1), '0);
    check_bit("local clear", 1'b1, rct_host_model_i.err_seen);
    rct_host_model_i.send(RCT_OP_CAL_RELOCK, 1'b1, '0, '0, '0);
    check_bit("cal open", 1'b0, cal_open);
    check_query(0, NCH - 1);
    rct_host_model_i.cal_clear(fid(0), fid(1), CODE, ue, ce, cw);
    check_bit("unlock err", 1'b0, ue);
    check_bit("clear err", 1'b0, ce);
    check_word("clear word", 32'h0, cw);
    check_bit("cal open", 1'b0, cal_open);
    exp_t[0] = 32'h0;
    exp_t[1] = 32'h0;
    check_query(0, NCH - 1);
  endtask : t_clear

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge mclk_i);
    bad_count++;
    stop_test();
  end

  // reset, then the scenarios
  initial begin
    rst_n_i      = 1'b0;
    relay_closed = '0;
    ee_ready     = 1'b0;
    stall_cnt    = 0;
    bad_count    = 0;
    check_count  = 0;
    foreach (exp_t[k])
      exp_t[k] = 32'h0;
    repeat (8) @(negedge mclk_i);
    rst_n_i = 1'b1;
    repeat (6) @(negedge mclk_i);
    t_reset();
    t_count();
    t_timer();
    t_period();
    t_refuse();
    t_clear();
    stop_test();
  end
endmodule : rct_tally_tb

`default_nettype wire
